// ==== hdl/exec_params.svh ====
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// =====================================================================
// Register map (byte addresses, low address bits only)
`define OFS_STATUS   8'h00
`define OFS_PC       8'h04
`define OFS_WORK     8'h08
`define OFS_IO       8'h0C
`define OFS_COMMAND  8'h10
`define OFS_STATE    8'h14

// =====================================================================
// Command word fields
`define CMD_OP_LSB   0
`define CMD_BIT_LSB  8
`define CMD_OFS_LSB  16

// =====================================================================
// Status register bit positions
`define SR_C 0
`define SR_Z 1
`define SR_N 2
`define SR_V 3
`define SR_S 4
`define SR_H 5
`define SR_T 6
`define SR_I 7

// =====================================================================
// Reset values and cycle counts
`define RST_STATUS   8'h00
`define RST_WORK     8'h00
`define RST_IO       8'h00
`define CYC_ONE      2'h1
`define CYC_TWO      2'h2

`endif

// ==== hdl/exec_pkg.sv ====
package exec_pkg;

    typedef enum logic [5:0] {
        op_nop                = 6'h00,
        branch_carry_one      = 6'h01,
        branch_carry_zero     = 6'h02,
        branch_same_or_higher = 6'h03,
        branch_if_lower       = 6'h04,
        branch_if_minus       = 6'h05,
        branch_if_plus        = 6'h06,
        branch_signed_ge      = 6'h07,
        branch_signed_lt      = 6'h08,
        branch_halfcarry_one  = 6'h09,
        branch_halfcarry_zero = 6'h0A,
        branch_tflag_one      = 6'h0B,
        branch_tflag_zero     = 6'h0C,
        branch_overflow_one   = 6'h0D,
        branch_overflow_zero  = 6'h0E,
        branch_irq_enabled    = 6'h0F,
        branch_irq_disabled   = 6'h10,
        io_bit_force_one      = 6'h11,
        io_bit_force_zero     = 6'h12,
        logical_left_shift    = 6'h13,
        logical_right_shift   = 6'h14,
        rotate_up_via_carry   = 6'h15,
        rotate_down_via_carry = 6'h16,
        arith_right_shift     = 6'h17,
        flag_index_on         = 6'h18,
        flag_index_off        = 6'h19,
        reg_bit_to_tflag      = 6'h1A,
        tflag_to_reg_bit      = 6'h1B,
        carry_on              = 6'h1C,
        carry_off             = 6'h1D,
        negative_on           = 6'h1E,
        negative_off          = 6'h1F,
        zero_flag_on          = 6'h20,
        zero_flag_off         = 6'h21,
        global_irq_on         = 6'h22,
        global_irq_off        = 6'h23,
        sign_flag_on          = 6'h24,
        sign_flag_off         = 6'h25,
        overflow_on           = 6'h26,
        overflow_off          = 6'h27,
        tflag_on              = 6'h28,
        tflag_off             = 6'h29,
        halfcarry_on          = 6'h2A,
        halfcarry_off         = 6'h2B
    } op_t;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_exec  = 3'b010,
        st_extra = 3'b100
    } exec_state_t;

    typedef struct packed {
        logic [7:0] offset;
        logic [2:0] bit_sel;
        op_t        op;
    } command_t;

    typedef struct packed {
        logic [7:0] value;
        logic       carry;
        logic       valid;
    } shift_result_t;

endpackage

// ==== hdl/branch_condition.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"

module branch_condition (
    input  wire exec_pkg::op_t op,
    input  wire logic [7:0]    status_register,
    output logic               is_branch,
    output logic               taken
);

    logic sr_sign_test;

    assign sr_sign_test = status_register[`SR_N] ^ status_register[`SR_V];

    always_comb begin
        is_branch = 1'b1;
        taken     = 1'b0;
        unique case (op)
            exec_pkg::branch_carry_one,
            exec_pkg::branch_if_lower:       taken = status_register[`SR_C];
            exec_pkg::branch_carry_zero,
            exec_pkg::branch_same_or_higher: taken = ~status_register[`SR_C];
            exec_pkg::branch_if_minus:       taken = status_register[`SR_N];
            exec_pkg::branch_if_plus:        taken = ~status_register[`SR_N];
            exec_pkg::branch_signed_ge:      taken = ~sr_sign_test;
            exec_pkg::branch_signed_lt:      taken = sr_sign_test;
            exec_pkg::branch_halfcarry_one:  taken = status_register[`SR_H];
            exec_pkg::branch_halfcarry_zero: taken = ~status_register[`SR_H];
            exec_pkg::branch_tflag_one:      taken = status_register[`SR_T];
            exec_pkg::branch_tflag_zero:     taken = ~status_register[`SR_T];
            exec_pkg::branch_overflow_one:   taken = status_register[`SR_V];
            exec_pkg::branch_overflow_zero:  taken = ~status_register[`SR_V];
            exec_pkg::branch_irq_enabled:    taken = status_register[`SR_I];
            exec_pkg::branch_irq_disabled:   taken = ~status_register[`SR_I];
            default:                         is_branch = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// ==== hdl/shift_unit.sv ====
`timescale 1ns/100ps
`default_nettype none

module shift_unit (
    input  wire exec_pkg::op_t       op,
    input  wire logic [7:0]          value,
    input  wire logic                carry_in,
    output exec_pkg::shift_result_t  result
);

    always_comb begin
        result = '{value: value, carry: carry_in, valid: 1'b0};
        unique case (op)
            exec_pkg::logical_left_shift:
                result = '{value: {value[6:0], 1'b0}, carry: value[7], valid: 1'b1};
            exec_pkg::logical_right_shift:
                result = '{value: {1'b0, value[7:1]}, carry: value[0], valid: 1'b1};
            exec_pkg::rotate_up_via_carry:
                result = '{value: {value[6:0], carry_in}, carry: value[7], valid: 1'b1};
            exec_pkg::rotate_down_via_carry:
                result = '{value: {carry_in, value[7:1]}, carry: value[0], valid: 1'b1};
            exec_pkg::arith_right_shift:
                result = '{value: {value[7], value[7:1]}, carry: value[0], valid: 1'b1};
            default: ;
        endcase
    end

endmodule
`default_nettype wire

// ==== hdl/branch_bit_flag_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"

module branch_bit_flag_exec #(
    parameter int PC_W     = 16,
    parameter int OFFSET_W = 7
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             busy,
    output logic [7:0]       status_register
);

    // =================================================================
    // Bus address phase capture
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic            next_wr_pend;
    logic [7:0]      next_wr_addr;
    logic [31:0]     next_hrdata;
    logic            addr_valid;

    // Hsize is not checked: only whole-word transfers are supported
    assign addr_valid = hsel & htrans[1] & hready;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    // =================================================================
    // Execution state
    exec_pkg::exec_state_t state;
    exec_pkg::exec_state_t next_state;
    exec_pkg::command_t    cmd;
    exec_pkg::command_t    next_cmd;
    logic [PC_W-1:0]       pc;
    logic [PC_W-1:0]       next_pc;
    logic [7:0]            work;
    logic [7:0]            next_work;
    logic [7:0]            io_reg;
    logic [7:0]            next_io_reg;
    logic [7:0]            next_status;
    logic                  last_taken;
    logic                  next_last_taken;
    logic [1:0]            last_cycles;
    logic [1:0]            next_last_cycles;

    logic                  is_branch;
    logic                  taken;
    logic                  two_cycle;
    logic                  commit;
    logic                  bus_write;
    logic                  flag_hit;
    logic [2:0]            flag_idx;
    logic                  flag_val;
    logic [PC_W-1:0]       offset_ext;
    exec_pkg::shift_result_t shifted;

    assign busy = (state != exec_pkg::st_idle);

    branch_condition u_cond (
        .op              (cmd.op),
        .status_register (status_register),
        .is_branch       (is_branch),
        .taken           (taken)
    );

    shift_unit u_shift (
        .op       (cmd.op),
        .value    (work),
        .carry_in (status_register[`SR_C]),
        .result   (shifted)
    );

    // Sign extension lets a branch reach backwards as well as forwards
    assign offset_ext = {{(PC_W-OFFSET_W){cmd.offset[OFFSET_W-1]}}, cmd.offset[OFFSET_W-1:0]};

    // =================================================================
    // Flag instruction decode
    always_comb begin
        flag_hit = 1'b1;
        flag_idx = cmd.bit_sel;
        flag_val = 1'b0;
        unique case (cmd.op)
            exec_pkg::flag_index_on:  flag_val = 1'b1;
            exec_pkg::flag_index_off: flag_val = 1'b0;
            exec_pkg::carry_on:       begin flag_idx = 3'(`SR_C); flag_val = 1'b1; end
            exec_pkg::carry_off:      begin flag_idx = 3'(`SR_C); flag_val = 1'b0; end
            exec_pkg::negative_on:    begin flag_idx = 3'(`SR_N); flag_val = 1'b1; end
            exec_pkg::negative_off:   begin flag_idx = 3'(`SR_N); flag_val = 1'b0; end
            exec_pkg::zero_flag_on:   begin flag_idx = 3'(`SR_Z); flag_val = 1'b1; end
            exec_pkg::zero_flag_off:  begin flag_idx = 3'(`SR_Z); flag_val = 1'b0; end
            exec_pkg::global_irq_on:  begin flag_idx = 3'(`SR_I); flag_val = 1'b1; end
            exec_pkg::global_irq_off: begin flag_idx = 3'(`SR_I); flag_val = 1'b0; end
            exec_pkg::sign_flag_on:   begin flag_idx = 3'(`SR_S); flag_val = 1'b1; end
            exec_pkg::sign_flag_off:  begin flag_idx = 3'(`SR_S); flag_val = 1'b0; end
            exec_pkg::overflow_on:    begin flag_idx = 3'(`SR_V); flag_val = 1'b1; end
            exec_pkg::overflow_off:   begin flag_idx = 3'(`SR_V); flag_val = 1'b0; end
            exec_pkg::tflag_on:       begin flag_idx = 3'(`SR_T); flag_val = 1'b1; end
            exec_pkg::tflag_off:      begin flag_idx = 3'(`SR_T); flag_val = 1'b0; end
            exec_pkg::halfcarry_on:   begin flag_idx = 3'(`SR_H); flag_val = 1'b1; end
            exec_pkg::halfcarry_off:  begin flag_idx = 3'(`SR_H); flag_val = 1'b0; end
            default:                  flag_hit = 1'b0;
        endcase
    end

    // =================================================================
    // Cycle budget: taken branches and I/O bit forcing need a second cycle
    assign two_cycle = (is_branch & taken)
                     | (cmd.op == exec_pkg::io_bit_force_one)
                     | (cmd.op == exec_pkg::io_bit_force_zero);
    assign commit    = ((state == exec_pkg::st_exec) & ~two_cycle) | (state == exec_pkg::st_extra);
    // Register writes are refused while an instruction is in flight
    assign bus_write = wr_pend & (state == exec_pkg::st_idle);

    // =================================================================
    // Execution next state
    always_comb begin
        next_state       = state;
        next_cmd         = cmd;
        next_pc          = pc;
        next_work        = work;
        next_io_reg      = io_reg;
        next_status      = status_register;
        next_last_taken  = last_taken;
        next_last_cycles = last_cycles;

        unique case (state)
            exec_pkg::st_idle: begin
                if (bus_write) begin
                    unique case (wr_addr)
                        `OFS_STATUS: next_status = hwdata[7:0];
                        `OFS_PC:     next_pc     = hwdata[PC_W-1:0];
                        `OFS_WORK:   next_work   = hwdata[7:0];
                        `OFS_IO:     next_io_reg = hwdata[7:0];
                        `OFS_COMMAND: begin
                            next_cmd.op      = exec_pkg::op_t'(hwdata[`CMD_OP_LSB +: 6]);
                            next_cmd.bit_sel = hwdata[`CMD_BIT_LSB +: 3];
                            next_cmd.offset  = hwdata[`CMD_OFS_LSB +: 8];
                            next_state       = exec_pkg::st_exec;
                        end
                        default: ;
                    endcase
                end
            end
            exec_pkg::st_exec: begin
                if (two_cycle) begin
                    next_state = exec_pkg::st_extra;
                end else begin
                    next_state = exec_pkg::st_idle;
                end
            end
            exec_pkg::st_extra: begin
                next_state = exec_pkg::st_idle;
            end
        endcase

        if (commit) begin
            next_last_cycles = two_cycle ? `CYC_TWO : `CYC_ONE;
            next_last_taken  = is_branch & taken;
            // Branches leave every flag as it was
            if (is_branch & taken) begin
                next_pc = PC_W'(pc + offset_ext + PC_W'(1));
            end else begin
                next_pc = PC_W'(pc + PC_W'(1));
            end
            if (cmd.op == exec_pkg::io_bit_force_one) begin
                next_io_reg[cmd.bit_sel] = 1'b1;
            end
            if (cmd.op == exec_pkg::io_bit_force_zero) begin
                next_io_reg[cmd.bit_sel] = 1'b0;
            end
            if (shifted.valid) begin
                next_work          = shifted.value;
                next_status[`SR_C] = shifted.carry;
                next_status[`SR_Z] = (shifted.value == 8'h00);
                next_status[`SR_N] = shifted.value[7];
                next_status[`SR_V] = shifted.value[7] ^ shifted.carry;
            end
            if (cmd.op == exec_pkg::reg_bit_to_tflag) begin
                next_status[`SR_T] = work[cmd.bit_sel];
            end
            if (cmd.op == exec_pkg::tflag_to_reg_bit) begin
                next_work[cmd.bit_sel] = status_register[`SR_T];
            end
            if (flag_hit) begin
                next_status[flag_idx] = flag_val;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state           <= exec_pkg::st_idle;
            cmd             <= '{offset: 8'h00, bit_sel: 3'h0, op: exec_pkg::op_nop};
            pc              <= '0;
            work            <= `RST_WORK;
            io_reg          <= `RST_IO;
            status_register <= `RST_STATUS;
            last_taken      <= 1'b0;
            last_cycles     <= 2'h0;
        end else begin
            state           <= next_state;
            cmd             <= next_cmd;
            pc              <= next_pc;
            work            <= next_work;
            io_reg          <= next_io_reg;
            status_register <= next_status;
            last_taken      <= next_last_taken;
            last_cycles     <= next_last_cycles;
        end
    end

    // =================================================================
    // Bus slave: read data is captured in the address phase
    always_comb begin
        next_wr_pend = addr_valid & hwrite;
        next_wr_addr = addr_valid ? haddr[7:0] : wr_addr;
        next_hrdata  = hrdata;
        if (addr_valid & ~hwrite) begin
            unique case (haddr[7:0])
                `OFS_STATUS:  next_hrdata = {24'h000000, status_register};
                `OFS_PC:      next_hrdata = 32'(pc);
                `OFS_WORK:    next_hrdata = {24'h000000, work};
                `OFS_IO:      next_hrdata = {24'h000000, io_reg};
                `OFS_COMMAND: next_hrdata = {8'h00, cmd.offset, 5'h00, cmd.bit_sel, 2'h0, cmd.op};
                `OFS_STATE:   next_hrdata = {28'h0000000, last_cycles, last_taken, busy};
                default:      next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= 32'h00000000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata  <= next_hrdata;
        end
    end

endmodule
`default_nettype wire

// ==== testbench/branch_bit_flag_exec_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"

// =====================================================================
// Port checker
module branch_bit_flag_exec_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        busy,
    input wire logic [7:0]  status_register
);
    logic        cmd_ap;
    logic        st_ap;
    logic        cmd_dp;
    logic        st_dp;
    logic [5:0]  dp_op;
    logic [31:0] cmd_word;
    logic [31:0] next_cmd_word;

    // Command writes taken while busy are dropped, so they start nothing
    assign cmd_ap = hsel && htrans[1] && hready && hwrite && (haddr[7:0] == `OFS_COMMAND) && !busy;
    assign st_ap  = hsel && htrans[1] && hready && hwrite && (haddr[7:0] == `OFS_STATUS);
    assign dp_op  = hwdata[5:0];

    always_comb begin
        next_cmd_word = cmd_dp ? hwdata : cmd_word;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_dp   <= 1'h0;
            st_dp    <= 1'h0;
            cmd_word <= 32'h0;
        end else begin
            cmd_dp   <= cmd_ap;
            st_dp    <= st_ap;
            cmd_word <= next_cmd_word;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // =====================================================================
    // Properties
    property p_no_wait; (hreadyout == 1'h1) && (hresp == 1'h0); endproperty
    a_no_wait: assert property (p_no_wait) else $error("slave stalled or errored");
    property p_busy_len; $rose(busy) |-> ##[1:2] !busy; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    // Flags move only at a commit or a direct status write
    property p_quiet; (!busy && !st_dp) |=> $stable(status_register); endproperty
    a_quiet: assert property (p_quiet) else $error("flags moved while idle");
    property p_branch_keep; (cmd_dp && dp_op >= 6'h01 && dp_op <= 6'h10) |=>
        $stable(status_register) [*3]; endproperty
    a_branch_keep: assert property (p_branch_keep) else $error("branch altered flags");
    property p_io_time; (cmd_dp && (dp_op == 6'h11 || dp_op == 6'h12)) |=> busy [*2] ##1 !busy; endproperty
    a_io_time: assert property (p_io_time) else $error("io force not two cycles");
    property p_one_time; (cmd_dp && dp_op >= 6'h13 && dp_op <= 6'h2B) |=> busy ##1 !busy; endproperty
    a_one_time: assert property (p_one_time) else $error("op not one cycle");
    property p_shift_flags; (cmd_dp && dp_op >= 6'h13 && dp_op <= 6'h17) |=> ##1
        (status_register[7:4] == $past(status_register[7:4])) &&
        (status_register[3] == (status_register[2] ^ status_register[0]));
    endproperty
    a_shift_flags: assert property (p_shift_flags) else $error("shift flags wrong");
    property p_index_on; (cmd_dp && dp_op == 6'h18) |=> ##1
        status_register == ($past(status_register) | (8'h01 << cmd_word[10:8])); endproperty
    a_index_on: assert property (p_index_on) else $error("indexed flag set wrong");
    property p_carry_on; (cmd_dp && dp_op == 6'h1C) |=> ##1
        status_register == ($past(status_register) | 8'h01); endproperty
    a_carry_on: assert property (p_carry_on) else $error("carry set wrong");
    property p_tcopy; (cmd_dp && dp_op == 6'h1A) |=> ##1
        (status_register & 8'hBF) == ($past(status_register) & 8'hBF); endproperty
    a_tcopy: assert property (p_tcopy) else $error("bit store touched other flags");
endmodule

bind branch_bit_flag_exec branch_bit_flag_exec_checker i_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .busy(busy), .status_register(status_register)
);
`default_nettype wire

// ==== testbench/branch_bit_flag_exec_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end

// =====================================================================
// Bench top, sole bus master
module branch_bit_flag_exec_tb_top;
    logic        hclk = 1'h0;
    logic        hresetn, hsel, hwrite, hready, hreadyout, hresp, busy;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  status_register;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    branch_bit_flag_exec i_branch_bit_flag_exec (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .busy(busy), .status_register(status_register)
    );

    // =====================================================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'h1;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        d = hrdata;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask

    // Polls STATE so no command is written while one is running
    task automatic run_op(input logic [5:0] op, input logic [2:0] b, input logic [6:0] ofs, output logic [31:0] st);
        int k;
        wr(`OFS_COMMAND, {8'h0, 1'h0, ofs, 5'h0, b, 2'h0, op});
        k = 0;
        st = 32'h1;
        while (st[0] !== 1'h0 && k < 8) begin
            rd(`OFS_STATE, st);
            k++;
        end
        `CHK(st[0], 1'h0)
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_regs();
        chk_reg(`OFS_STATUS, 32'h0);
        chk_reg(`OFS_WORK, 32'h0);
        wr(`OFS_PC, 32'hFFFF_FFFF);
        chk_reg(`OFS_PC, 32'h0000_FFFF);
        wr(8'h18, 32'hFFFF_FFFF);
        chk_reg(8'h18, 32'h0);
        $display("register test done");
    endtask

    task automatic t_branch();
        logic [7:0]  pat [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
        logic [6:0]  ofs;
        logic [15:0] tgt;
        logic [31:0] st;
        logic        f, tk;
        for (int o = 1; o <= 16; o++) begin
            for (int p = 0; p < 4; p++) begin
                ofs = p[0] ? 7'h7D : 7'h05;
                f = (o <= 4) ? pat[p][0] : (o <= 6) ? pat[p][2] : (o <= 8) ? pat[p][2] ^ pat[p][3] :
                    (o <= 10) ? pat[p][5] : (o <= 12) ? pat[p][6] : (o <= 14) ? pat[p][3] : pat[p][7];
                tk = (o inside {1, 4, 5, 8, 9, 11, 13, 15}) ? f : !f;
                wr(`OFS_STATUS, {24'h0, pat[p]});
                wr(`OFS_PC, 32'h0000_0100);
                run_op(6'(o), 3'h0, ofs, st);
                tgt = tk ? 16'h0101 + {{9{ofs[6]}}, ofs} : 16'h0101;
                chk_reg(`OFS_PC, {16'h0, tgt});
                `CHK(st[3:1], {tk ? 2'h2 : 2'h1, tk})
                chk_reg(`OFS_STATUS, {24'h0, pat[p]});
            end
        end
        $display("branch test done");
    endtask

    task automatic t_io();
        logic [7:0]  v;
        logic [31:0] st;
        v = 8'h00;
        wr(`OFS_IO, 32'h0);
        wr(`OFS_STATUS, 32'h0000_00A5);
        for (int b = 0; b < 16; b++) begin
            run_op(b < 8 ? 6'h11 : 6'h12, 3'(b), 7'h0, st);
            v[b % 8] = (b < 8);
            chk_reg(`OFS_IO, {24'h0, v});
            `CHK(st[3:2], 2'h2)
        end
        // Status write lands while the force still runs, so it must be dropped
        wr(`OFS_COMMAND, 32'h0000_0011);
        wr(`OFS_STATUS, 32'h0);
        chk_reg(`OFS_IO, 32'h0000_0001);
        chk_reg(`OFS_STATUS, 32'h0000_00A5);
        $display("io test done");
    endtask

    task automatic t_shift();
        logic [7:0]  vals [4] = '{8'h81, 8'h80, 8'h01, 8'h40};
        logic [7:0]  v, r;
        logic        c, co;
        logic [31:0] st;
        for (int o = 19; o <= 23; o++) begin
            for (int i = 0; i < 8; i++) begin
                v = vals[i / 2];
                c = i[0];
                case (o)
                    19: {co, r} = {v, 1'h0};
                    20: {r, co} = {1'h0, v};
                    21: {co, r} = {v, c};
                    22: {r, co} = {c, v};
                    default: {r, co} = {v[7], v};
                endcase
                wr(`OFS_STATUS, {24'h0, 4'hA, 3'h0, c});
                wr(`OFS_WORK, {24'h0, v});
                run_op(6'(o), 3'h0, 7'h0, st);
                chk_reg(`OFS_WORK, {24'h0, r});
                chk_reg(`OFS_STATUS, {24'h0, 4'hA, co ^ r[7], r[7], r == 8'h00, co});
                `CHK(st[3:2], 2'h1)
            end
        end
        $display("shift test done");
    endtask

    task automatic t_flags();
        logic [2:0]  idx [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};
        logic [2:0]  b;
        logic [7:0]  m;
        logic [31:0] st;
        for (int k = 0; k < 32; k++) begin
            b = (k < 16) ? idx[k / 2] : 3'(k / 2);
            m = 8'h01 << b;
            wr(`OFS_STATUS, 32'h0000_00A5);
            run_op((k < 16) ? 6'h1C + 6'(k) : 6'h18 + 6'(k % 2), b, 7'h0, st);
            chk_reg(`OFS_STATUS, {24'h0, k[0] ? (8'hA5 & ~m) : (8'hA5 | m)});
            `CHK(st[3:2], 2'h1)
        end
        $display("flag test done");
    endtask

    task automatic t_bits();
        logic [7:0]  w, e, s;
        logic [31:0] st;
        w = 8'h5A;
        for (int b = 0; b < 8; b++) begin
            wr(`OFS_WORK, {24'h0, w});
            wr(`OFS_STATUS, 32'h0000_00BF);
            run_op(6'h1A, 3'(b), 7'h0, st);
            s = {1'h1, w[b], 6'h3F};
            chk_reg(`OFS_STATUS, {24'h0, s});
            run_op(6'h1B, 3'(b ^ 1), 7'h0, st);
            e = w;
            e[b ^ 1] = w[b];
            chk_reg(`OFS_WORK, {24'h0, e});
            chk_reg(`OFS_STATUS, {24'h0, s});
            `CHK(st[3:2], 2'h1)
        end
        $display("bit copy test done");
    endtask

    // =====================================================================
    // Run control
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 2100 cycles; the ceiling leaves ample slack
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        hresetn = 1'h0;
        hsel = 1'h1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_regs();
        t_branch();
        t_io();
        t_shift();
        t_flags();
        t_bits();
        close_out();
    end
endmodule
`default_nettype wire
